// File: stp_consts.vh
`ifndef STP_CONSTS_VH
`define STP_CONSTS_VH
// Register map
`define STP_ADDR_W          8
`define STP_GTC_ADDR        8'h23
`define STP_GTC_RESET       8'h00
`define STP_BIT_SYNC_RST    0
`define STP_BIT_ASYNC_RST   1
`define STP_BIT_HOLD_MODE   7
// Clock select codes
`define STP_CS_STOP         3'h0
`define STP_CS_DIRECT       3'h1
`define STP_CS_DIV8         3'h2
`define STP_CS_DIV64        3'h3
`define STP_CS_DIV256       3'h4
`define STP_CS_DIV1024      3'h5
`define STP_CS_EXT_FALL     3'h6
`define STP_CS_EXT_RISE     3'h7
// Divider
`define STP_DIV_W           10
`define STP_DIV_ZERO        10'h000
`define STP_DIV_ONE         10'h001
`define STP_TAP8_MASK       10'h007
`define STP_TAP64_MASK      10'h03f
`define STP_TAP256_MASK     10'h0ff
`define STP_TAP1024_MASK    10'h3ff
`endif

// File: stp_prescaler.v
`include "stp_consts.vh"
// Shared free-running divider with four taps
module stp_prescaler (
  input  wire       clk,
  input  wire       nrst,
  input  wire       div_clear,
  output reg  [3:0] tap_pulse
);
  reg  [`STP_DIV_W-1:0] count_reg;
  wire [`STP_DIV_W-1:0] count_next;
  wire [`STP_DIV_W-1:0] masks [0:3];

  assign masks[0] = `STP_TAP8_MASK;
  assign masks[1] = `STP_TAP64_MASK;
  assign masks[2] = `STP_TAP256_MASK;
  assign masks[3] = `STP_TAP1024_MASK;
  assign count_next = count_reg + `STP_DIV_ONE;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= `STP_DIV_ZERO;
    end else if (div_clear) begin
      count_reg <= `STP_DIV_ZERO; // [RULE5]
    end else begin
      count_reg <= count_next; // [RULE3]
    end
  end

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_tap
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          tap_pulse[i] <= 1'b0;
        end else begin
          tap_pulse[i] <= !div_clear && ((count_reg & masks[i]) == masks[i]); // [RULE2]
        end
      end
    end
  endgenerate
endmodule // stp_prescaler

// File: stp_pin_sync.v
`include "stp_consts.vh"
// Count pin sampler and edge detector
module stp_pin_sync (
  input  wire clk,
  input  wire nrst,
  input  wire pin_in,
  output wire rise_pulse,
  output wire fall_pulse
);
  reg latch_reg;
  reg sync_reg;
  reg prev_reg;

  // High-phase transparent stage, modelled as a sample each cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latch_reg <= 1'b0;
      sync_reg  <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      latch_reg <= pin_in;    // [RULE6]
      sync_reg  <= latch_reg; // [RULE6]
      prev_reg  <= sync_reg;
    end
  end

  assign rise_pulse = sync_reg & ~prev_reg;  // [RULE7]
  assign fall_pulse = ~sync_reg & prev_reg;  // [RULE7]
endmodule // stp_pin_sync

// File: stp_timer_clock.v
// The strobed register port is this design's own decision.
`include "stp_consts.vh"
// Notes on behaviour
// [RULE1] Select code 1 counts every system clock cycle, undivided.
// [RULE2] Four divided taps: system clock over 8, 64, 256, 1024.
// [RULE3] One free-running divider shared by both timers, independent of select.
// [RULE4] First divided count comes 1 to N+1 cycles after enable.
// [RULE5] Prescaler reset restarts the divider phase for both timers together.
// [RULE6] Count pin sampled every cycle through latch then rising-edge registers.
// [RULE7] Code 7 pulses on rising pin edges, code 6 on falling edges.
// [RULE8] Counter updates 2.5 to 3.5 cycles after a pin edge.
// [RULE9] Other party switches external input only while pin is steady.
// [RULE10] External clock phases each longer than one system clock cycle.
// [RULE11] Pin-derived pulses are never prescaled.
// [RULE12] Hold mode keeps written reset bits, holding resets asserted.
// [RULE13] Clearing hold mode clears both reset bits so timers start together.
// [RULE14] Sync reset bit resets shared divider; self-clears unless hold mode.
// [RULE15] Pin edges count even while the pin is driven as an output.
// [RULE16] Async reset bit resets async prescaler; self-clears unless hold mode.
module stp_timer_clock (
  input  wire                   clk,
  input  wire                   nrst,
  input  wire [`STP_ADDR_W-1:0] reg_addr,
  input  wire [7:0]             reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [7:0]             reg_rdata,
  input  wire [2:0]             clock_select_field0,
  input  wire [2:0]             clock_select_field1,
  input  wire                   external_count_pin0,
  input  wire                   external_count_pin1,
  output wire                   timer_count_clock0,
  output wire                   timer_count_clock1,
  output wire                   async_prescaler_reset
);
  ////////////////////////////////////////////////////////////////////////////
  // Control register
  reg        sync_hold_mode_reg;
  reg        sync_prescaler_reset_reg;
  reg        async_prescaler_reset_reg;
  reg        sync_hold_mode_next;
  reg        sync_prescaler_reset_next;
  reg        async_prescaler_reset_next;
  wire       gtc_hit;
  wire [7:0] gtc_value;

  assign gtc_hit = (reg_addr == `STP_GTC_ADDR);

  always @* begin
    sync_hold_mode_next        = sync_hold_mode_reg;
    sync_prescaler_reset_next  = sync_prescaler_reset_reg;
    async_prescaler_reset_next = async_prescaler_reset_reg;
    if (reg_wr && gtc_hit) begin
      sync_hold_mode_next        = reg_wdata[`STP_BIT_HOLD_MODE];
      sync_prescaler_reset_next  = reg_wdata[`STP_BIT_SYNC_RST];  // [RULE12]
      async_prescaler_reset_next = reg_wdata[`STP_BIT_ASYNC_RST]; // [RULE12]
      if (!reg_wdata[`STP_BIT_HOLD_MODE]) begin
        // Pulse for one cycle, then cleared below
        sync_prescaler_reset_next  = reg_wdata[`STP_BIT_SYNC_RST];
        async_prescaler_reset_next = reg_wdata[`STP_BIT_ASYNC_RST];
      end
    end else if (!sync_hold_mode_reg) begin
      sync_prescaler_reset_next  = 1'b0; // [RULE14] [RULE13]
      async_prescaler_reset_next = 1'b0; // [RULE16] [RULE13]
    end
    if (reg_wr && gtc_hit && sync_hold_mode_reg && !reg_wdata[`STP_BIT_HOLD_MODE]) begin
      sync_prescaler_reset_next  = 1'b0; // [RULE13]
      async_prescaler_reset_next = 1'b0; // [RULE13]
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_hold_mode_reg        <= 1'b0;
      sync_prescaler_reset_reg  <= 1'b0;
      async_prescaler_reset_reg <= 1'b0;
    end else begin
      sync_hold_mode_reg        <= sync_hold_mode_next;
      sync_prescaler_reset_reg  <= sync_prescaler_reset_next;
      async_prescaler_reset_reg <= async_prescaler_reset_next;
    end
  end

  assign gtc_value = {sync_hold_mode_reg, 5'h00,
                      async_prescaler_reset_reg, sync_prescaler_reset_reg};

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= `STP_GTC_RESET;
    end else if (reg_rd && gtc_hit) begin
      reg_rdata <= gtc_value;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  assign async_prescaler_reset = async_prescaler_reset_reg; // [RULE16]

  ////////////////////////////////////////////////////////////////////////////
  // Shared divider
  wire [3:0] tap_pulse;

  stp_prescaler u_prescaler (
    .clk       (clk),
    .nrst      (nrst),
    .div_clear (sync_prescaler_reset_reg), // [RULE14] [RULE5]
    .tap_pulse (tap_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-timer source selection
  wire [2:0] sel   [0:1];
  wire       pin   [0:1];
  wire       rise  [0:1];
  wire       fall  [0:1];
  reg        pulse [0:1];

  assign sel[0] = clock_select_field0;
  assign sel[1] = clock_select_field1;
  assign pin[0] = external_count_pin0; // [RULE15]
  assign pin[1] = external_count_pin1;

  genvar t;
  generate
    for (t = 0; t < 2; t = t + 1) begin : g_timer
      stp_pin_sync u_pin_sync (
        .clk        (clk),
        .nrst       (nrst),
        .pin_in     (pin[t]),
        .rise_pulse (rise[t]),
        .fall_pulse (fall[t])
      );

      always @* begin
        case (sel[t])
          `STP_CS_STOP:     pulse[t] = 1'b0;
          `STP_CS_DIRECT:   pulse[t] = 1'b1;          // [RULE1]
          `STP_CS_DIV8:     pulse[t] = tap_pulse[0];  // [RULE2] [RULE4]
          `STP_CS_DIV64:    pulse[t] = tap_pulse[1];  // [RULE2]
          `STP_CS_DIV256:   pulse[t] = tap_pulse[2];  // [RULE2]
          `STP_CS_DIV1024:  pulse[t] = tap_pulse[3];  // [RULE2]
          `STP_CS_EXT_FALL: pulse[t] = fall[t];       // [RULE7] [RULE11] [RULE8]
          `STP_CS_EXT_RISE: pulse[t] = rise[t];       // [RULE7] [RULE11] [RULE8]
          default:          pulse[t] = 1'b0;
        endcase
      end
    end
  endgenerate

  assign timer_count_clock0 = pulse[0];
  assign timer_count_clock1 = pulse[1];
endmodule // stp_timer_clock

// File: stp_asserts.sv
module stp_checker (
  input wire       clk,
  input wire       nrst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire [2:0] clock_select_field0,
  input wire [2:0] clock_select_field1,
  input wire       external_count_pin0,
  input wire       external_count_pin1,
  input wire       timer_count_clock0,
  input wire       timer_count_clock1,
  input wire       async_prescaler_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire [2:0] s0 = clock_select_field0;
  wire [2:0] s1 = clock_select_field1;
  wire       c0 = timer_count_clock0;
  wire       c1 = timer_count_clock1;
  wire       wr = reg_wr && reg_addr == 8'h23;
  a_direct_level: assert property (s0 == 3'h1 |-> c0)
    else $error("direct select not counting");
  a_div8_period: assert property (
    c0 && s0 == 3'h2 && !wr ##1 (s0 == 3'h2 && !wr) [*8] |-> c0) else $error("tap not 8");
  a_pulse_once: assert property (c1 && s1 != 3'h1 ##1 $stable(s1) |-> !c1)
    else $error("pulse wider than one cycle");
  a_pin_rise: assert property (
    s0 == 3'h7 && $rose(external_count_pin0) ##1 (s0 == 3'h7) [*2] |-> ##[0:1] c0)
    else $error("rising pin edge not counted");
  a_pin_fall: assert property (
    s1 == 3'h6 && $fell(external_count_pin1) ##1 (s1 == 3'h6) [*2] |-> ##[0:1] c1)
    else $error("falling pin edge not counted");
  a_sync_restart: assert property (wr && reg_wdata[0] |=> ##1 (!c0 || s0 != 3'h2) [*8])
    else $error("divider not restarted");
  a_async_pulse: assert property (wr && !reg_wdata[7] && reg_wdata[1] |=> async_prescaler_reset)
    else $error("async reset not raised");
  a_hold_keeps: assert property (
    wr && reg_wdata[7] && reg_wdata[1] ##1 !wr [*8] |-> async_prescaler_reset)
    else $error("held reset dropped");
  a_hold_release: assert property (
    wr && !reg_wdata[7] ##1 !wr [*3] |-> !async_prescaler_reset) else $error("reset not cleared");
  c_pin_rise: cover property (s0 == 3'h7 && c0);
  c_pin_fall: cover property (s1 == 3'h6 && c1);
  c_hold: cover property (async_prescaler_reset);
endmodule // stp_checker

bind stp_timer_clock stp_checker stp_checker_inst (.*);

// File: stp_ext_src.sv
module stp_ext_src #(
  parameter int H0 = 4,
  parameter int H1 = 8
) (
  input  wire  clk,
  input  wire  run,
  output logic pin0,
  output logic pin1
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  initial pin0 = 1'b0;
  initial pin1 = 1'b0;
  // Square waves, frozen while stopped
  always @(posedge clk) begin
    if (run) begin
      n <= n + 1;
      if ((n + 1) % H0 == 0) pin0 <= !pin0;
      if ((n + 1) % H1 == 0) pin1 <= !pin1;
    end
  end
endmodule // stp_ext_src

// File: tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, nrst, wr_s, rd_s, run;
  logic [7:0] addr, wdata, q;
  logic [2:0] s0, s1;
  wire  [7:0] rdata;
  wire        p0, p1, c0, c1, apr;
  int         n_errors = 0, n_checks = 0, k0, k1;
  int rows[6][4] = '{'{1, 7, 2048, 128}, '{0, 6, 0, 128}, '{2, 3, 256, 32},
                     '{4, 5, 8, 2}, '{6, 2, 256, 256}, '{7, 4, 256, 8}};
  stp_timer_clock stp_timer_clock_inst (.clk(clk), .nrst(nrst), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata),
    .clock_select_field0(s0), .clock_select_field1(s1), .external_count_pin0(p0),
    .external_count_pin1(p1), .timer_count_clock0(c0), .timer_count_clock1(c1),
    .async_prescaler_reset(apr));
  stp_ext_src stp_ext_src_inst (.clk(clk), .run(run), .pin0(p0), .pin1(p1));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  // Pulses of both timers over n cycles
  task automatic cnt(input int n, output int a, output int b);
    a = 0;
    b = 0;
    repeat (n) begin
      @(posedge clk);
      #1 a += c0;
      b += c1;
    end
    @(posedge clk);
  endtask
  // Cycles to first pulse of each timer
  task automatic first(output int a, output int b);
    int t;
    a = 0;
    b = 0;
    t = 0;
    while ((a == 0 || b == 0) && t < 2000) begin
      #1 t++;
      if (c0 === 1'b1 && a == 0) a = t;
      if (c1 === 1'b1 && b == 0) b = t;
      @(posedge clk);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #300us;
    n_errors++;
    print_verdict();
  end
  initial begin
    {nrst, wr_s, rd_s, run, addr, wdata, s0, s1} = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      run <= 1'b0;
      repeat (4) @(posedge clk);
      s0 <= rows[i][0][2:0];
      s1 <= rows[i][1][2:0];
      repeat (4) @(posedge clk);
      run <= 1'b1;
      repeat (8) @(posedge clk);
      cnt(2048, k0, k1);
      check(k0, rows[i][2]);
      check(k1, rows[i][3]);
    end
    run <= 1'b0;
    s0 <= 3'h0;
    s1 <= 3'h0;
    repeat (4) @(posedge clk);
    s0 <= 3'h2;
    s1 <= 3'h2;
    first(k0, k1);
    check(k0 >= 1 && k0 <= 9, 1);
    check(k0, k1);
    s1 <= 3'h3;
    wr(8'h23, 8'h01);
    first(k0, k1);
    check(k1 - k0, 56);
    wr(8'h23, 8'hff);
    rd(8'h23, q);
    check(q, 8'h83);
    cnt(16, k0, k1);
    check({apr, k0[7:0], k1[7:0]}, 17'h10000);
    wr(8'h23, 8'h00);
    rd(8'h23, q);
    check({apr, q}, 9'h000);
    wr(8'h23, 8'h02);
    @(posedge clk);
    rd(8'h23, q);
    check(q, 8'h00);
    wr(8'h24, 8'h81);
    rd(8'h24, q);
    check(q, 8'h00);
    rd(8'h23, q);
    check(q, 8'h00);
    wr(8'h23, 8'h81);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(8'h23, q);
    check({apr, q}, 9'h000);
    print_verdict();
  end
endmodule // tb_top
